//--- logic/bsalu_pkg.sv
// constants, types and decode helpers for the two-bit alu slice
// Operation
// - add, inc, dec, shifts, logic ops supported
// - result goes to accumulator, register, or both
// - generate, propagate, left input, right output cascade
// - memory bus enters only via operand a
// - io bus enters via operand b, and via operand a in group 2
// - all-ones mask includes accumulator, zeros exclude
// - logic groups or masked operand into carry
// - address register drives three-state address bus
// - accumulator copy drives three-state data bus
// - group 0 reg: reg+masked acc+carry to both
// - group 0 on accumulator with mask 11 shifts it left
// - memory plus masked acc plus carry to target
// - group 0 third group shifts right for any mask
// - group 1 reg: address gets reg or mask
// - group 1 reg mask 11: address all ones, decrement
// - group 1 memory: address gets memory or mask
// - group 1 memory mask 11: ones, memory minus one
// - group 1 third: complement-or plus and plus carry
// - group 1 third mask 11 decrements target
// - group 2: masked operand minus one plus carry
// - group 2 mask 00: carry minus one
// - group 3 reg: sum to register, accumulator kept
// - seven-bit code: group high, registers low
// - eleven scratchpad registers feed operand a
// - carry out off, right out on, during shift
package bsalu_pkg;
    localparam int SLICE_W = 2;
    localparam int FUNC_W = 7;
    localparam int NUM_SCRATCH = 11;
    localparam logic [3:0] TEMP_IDX = 4'ha;
    localparam logic [2:0] GRP_SUM_BOTH = 3'h0;
    localparam logic [2:0] GRP_ADDR_LOAD = 3'h1;
    localparam logic [2:0] GRP_DEC = 3'h2;
    localparam logic [2:0] GRP_SUM_REG = 3'h3;
    localparam logic [3:0] RSEL_LAST_GP = 4'h9;
    localparam logic [3:0] RSEL_T_I = 4'hc;
    localparam logic [3:0] RSEL_AC_I = 4'hd;
    localparam logic [3:0] RSEL_T_II = 4'ha;
    localparam logic [3:0] RSEL_AC_II = 4'hb;
    localparam logic [3:0] RSEL_T_III = 4'he;
    localparam logic [3:0] RSEL_AC_III = 4'hf;
    localparam logic [1:0] MASK_ZERO = 2'h0;
    localparam logic [1:0] MASK_ONES = 2'h3;
    localparam logic [1:0] RST_WORD = 2'h0;
    localparam logic [1:0] RST_SYNC_INIT = 2'h0;

    typedef enum logic [2:0] {
        RG_I = 3'b001,
        RG_II = 3'b010,
        RG_III = 3'b100
    } bsalu_rgrp_e;

    // register group from the low four function bits
    function automatic bsalu_rgrp_e bsalu_rgrp(input logic [3:0] code);
        if (code == RSEL_T_II || code == RSEL_AC_II) begin
            return RG_II;
        end
        if (code == RSEL_T_III || code == RSEL_AC_III) begin
            return RG_III;
        end
        return RG_I;
    endfunction
endpackage

//--- logic/bsalu_add_if.sv
// operand and result bundle between control and adder
`timescale 1ns/1ps
`default_nettype none
interface bsalu_add_if;
    logic [1:0] opa;
    logic [1:0] opb;
    logic cin;
    logic [1:0] sum;
    logic cout;
    logic gen;
    logic prop;
    modport adder (input opa, input opb, input cin,
                   output sum, output cout, output gen, output prop);
    modport ctl (output opa, output opb, output cin,
                 input sum, input cout, input gen, input prop);
endinterface
`default_nettype wire

//--- logic/bsalu_adder.sv
// two-bit adder with look-ahead generate and propagate
`timescale 1ns/1ps
`default_nettype none
module bsalu_adder
    import bsalu_pkg::*;
(
    bsalu_add_if.adder add_if
);
    logic [1:0] g;
    logic [1:0] p;
    logic c1;

    // per-bit terms, then ripple inside the slice
    assign g = add_if.opa & add_if.opb;
    assign p = add_if.opa | add_if.opb;
    assign c1 = g[0] | (p[0] & add_if.cin);
    assign add_if.sum = add_if.opa ^ add_if.opb ^ {c1, add_if.cin};
    assign add_if.cout = g[1] | (p[1] & c1);
    // group terms for an external look-ahead unit
    assign add_if.gen = g[1] | (p[1] & g[0]);
    assign add_if.prop = p[1] & p[0];
endmodule
`default_nettype wire

//--- logic/bsalu_slice.sv
// top of the two-bit alu slice: registers, decode and buses
`timescale 1ns/1ps
`default_nettype none
module bsalu_slice
    import bsalu_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [FUNC_W-1:0] func_in,
    input wire logic [SLICE_W-1:0] mask_in,
    input wire logic [SLICE_W-1:0] mem_data_in,
    input wire logic [SLICE_W-1:0] io_data_in,
    input wire logic carry_input_in,
    input wire logic left_fill_input_in,
    input wire logic addr_enable_in,
    input wire logic data_enable_in,
    output logic cla_gen_out,
    output logic cla_prop_out,
    output logic carry_output_out,
    output logic carry_output_oe_out,
    output logic shift_right_out_out,
    output logic shift_right_out_oe_out,
    output logic [SLICE_W-1:0] addr_out,
    output logic addr_oe_out,
    output logic [SLICE_W-1:0] data_out,
    output logic data_oe_out
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [SLICE_W-1:0] scratch_q [NUM_SCRATCH];
    logic [SLICE_W-1:0] acc_q;
    logic [SLICE_W-1:0] addr_hold_q;
    logic [2:0] grp;
    logic [3:0] rsel;
    bsalu_rgrp_e rgrp;
    logic [3:0] rn_idx;
    logic rn_is_acc;
    logic [SLICE_W-1:0] rn;
    logic [SLICE_W-1:0] at;
    logic [SLICE_W-1:0] k;
    logic arith;
    logic shift;
    logic wr_rn;
    logic wr_at;
    logic wr_acc;
    logic addr_ld;
    logic [SLICE_W-1:0] addr_d;
    logic [SLICE_W-1:0] result;
    logic [SLICE_W-1:0] test_opnd;
    bsalu_add_if add_if ();

    // reset is released through two flops so its removal is clean
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_q <= RST_SYNC_INIT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // split the function code into group and register fields
    assign grp = func_in[6:4];
    assign rsel = func_in[3:0];
    assign rgrp = bsalu_rgrp(rsel);
    assign k = mask_in;

    // scratchpad selection; code for the accumulator aliases it
    assign rn_is_acc = (rsel == RSEL_AC_I);
    assign rn_idx = (rsel == RSEL_T_I) ? TEMP_IDX : rsel;
    assign rn = rn_is_acc ? acc_q :
                ((rsel <= RSEL_LAST_GP || rsel == RSEL_T_I) ?
                 scratch_q[rn_idx] : RST_WORD);
    // low code bit picks accumulator over temporary
    assign at = rsel[0] ? acc_q : scratch_q[TEMP_IDX];

    bsalu_adder u_adder (
        .add_if(add_if.adder)
    );

    // operand steering and write enables per microfunction
    always_comb begin
        add_if.opa = RST_WORD;
        add_if.opb = RST_WORD;
        add_if.cin = carry_input_in;
        arith = 1'b1;
        shift = 1'b0;
        wr_rn = 1'b0;
        wr_at = 1'b0;
        wr_acc = 1'b0;
        addr_ld = 1'b0;
        addr_d = addr_hold_q;
        test_opnd = RST_WORD;
        unique case (grp)
            GRP_SUM_BOTH: begin
                unique case (rgrp)
                    RG_I: begin
                        add_if.opa = rn;
                        add_if.opb = acc_q & k;
                        wr_rn = 1'b1;
                        wr_acc = 1'b1;
                    end
                    RG_II: begin
                        add_if.opa = mem_data_in;
                        add_if.opb = acc_q & k;
                        wr_at = 1'b1;
                    end
                    RG_III: begin
                        // plain one-bit shift for any mask value
                        shift = 1'b1;
                        wr_at = 1'b1;
                    end
                endcase
            end
            GRP_ADDR_LOAD: begin
                addr_ld = 1'b1;
                unique case (rgrp)
                    RG_I: begin
                        addr_d = rn | k;
                        add_if.opa = rn;
                        add_if.opb = k;
                        wr_rn = 1'b1;
                    end
                    RG_II: begin
                        addr_d = mem_data_in | k;
                        add_if.opa = mem_data_in;
                        add_if.opb = k;
                        wr_at = 1'b1;
                    end
                    RG_III: begin
                        addr_ld = 1'b0;
                        add_if.opa = ~at | k;
                        add_if.opb = at & k;
                        wr_at = 1'b1;
                    end
                endcase
            end
            GRP_DEC: begin
                // all-ones operand b subtracts one
                add_if.opa = ((rgrp == RG_III) ? io_data_in : acc_q) & k;
                add_if.opb = MASK_ONES;
                wr_rn = (rgrp == RG_I);
                wr_at = (rgrp != RG_I);
            end
            GRP_SUM_REG: begin
                unique case (rgrp)
                    RG_I: begin
                        add_if.opa = rn;
                        add_if.opb = acc_q & k;
                        wr_rn = 1'b1;
                    end
                    RG_II: begin
                        add_if.opa = mem_data_in;
                        add_if.opb = acc_q & k;
                        wr_at = 1'b1;
                    end
                    RG_III: begin
                        add_if.opa = at;
                        add_if.opb = io_data_in & k;
                        wr_at = 1'b1;
                    end
                endcase
            end
            default: begin
                // logic groups here only test: no register is written
                arith = 1'b0;
                test_opnd = (rgrp == RG_I) ? rn :
                            ((rgrp == RG_II) ? mem_data_in : at);
            end
        endcase
    end

    // shift result bypasses the adder
    assign result = shift ? {left_fill_input_in, at[1]} : add_if.sum;

    // scratchpad writes, all on the one edge ending the cycle
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SCRATCH; i++) begin
                scratch_q[i] <= RST_WORD;
            end
        end else begin
            if (wr_rn && !rn_is_acc) begin
                scratch_q[rn_idx] <= result;
            end
            if (wr_at && !rsel[0]) begin
                scratch_q[TEMP_IDX] <= result;
            end
        end
    end

    // accumulator update
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= RST_WORD;
        end else if (wr_acc || (wr_rn && rn_is_acc) ||
                     (wr_at && rsel[0])) begin
            acc_q <= result;
        end
    end

    // address register update
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            addr_hold_q <= RST_WORD;
        end else if (addr_ld) begin
            addr_hold_q <= addr_d;
        end
    end

    // cascade pins; carry pin floats while the right pin is used
    assign cla_gen_out = add_if.gen;
    assign cla_prop_out = add_if.prop;
    assign carry_output_out = arith ? add_if.cout :
        (carry_input_in | (|(test_opnd & k)));
    assign carry_output_oe_out = !shift;
    assign shift_right_out_out = shift & at[0];
    assign shift_right_out_oe_out = shift;

    // buses come straight from flops; enables from the pins
    assign addr_out = addr_hold_q;
    assign addr_oe_out = addr_enable_in;
    assign data_out = acc_q;
    assign data_oe_out = data_enable_in;

    // ---- checks ----
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n);

    sequence s_gp_reg_op(logic [2:0] g);
        grp == g && rgrp == RG_I && rsel <= RSEL_LAST_GP;
    endsequence

    sequence s_shift_acc;
        grp == GRP_SUM_BOTH && rsel == RSEL_AC_III;
    endsequence

    AST_SUM_TO_BOTH: assert property (
        s_gp_reg_op(GRP_SUM_BOTH) |=>
        acc_q == scratch_q[$past(rsel)] &&
        acc_q == 2'($past(scratch_q[rsel]) + ($past(acc_q) & $past(k))
                    + {1'b0, $past(carry_input_in)}))
        else $error("sum not written to register and accumulator");

    AST_SHIFT_LEFT: assert property (
        grp == GRP_SUM_BOTH && rsel == RSEL_AC_I && k == MASK_ONES |=>
        acc_q == {$past(acc_q[0]), $past(carry_input_in)})
        else $error("accumulator added to itself is not a left shift");

    AST_MEM_PLUS_ACC: assert property (
        (grp == GRP_SUM_BOTH || grp == GRP_SUM_REG) && rsel == RSEL_AC_II
        |=> acc_q == 2'($past(mem_data_in) + ($past(acc_q) & $past(k))
                        + {1'b0, $past(carry_input_in)}))
        else $error("memory plus masked accumulator wrong");

    AST_SHIFT_RIGHT: assert property (
        s_shift_acc |-> shift_right_out_oe_out &&
        shift_right_out_out == acc_q[0] ##1
        acc_q == {$past(left_fill_input_in), $past(acc_q[1])})
        else $error("right shift of accumulator wrong");

    AST_ADDR_FROM_REG: assert property (
        s_gp_reg_op(GRP_ADDR_LOAD) |=>
        addr_out == ($past(scratch_q[rsel]) | $past(k)))
        else $error("address register not loaded with reg or mask");

    AST_ADDR_ALL_ONES: assert property (
        grp == GRP_ADDR_LOAD && rgrp != RG_III && k == MASK_ONES |=>
        addr_out == MASK_ONES ##1 ($stable(addr_out) || $past(addr_ld)))
        else $error("address register not forced to all ones");

    AST_COMPLEMENT: assert property (
        grp == GRP_ADDR_LOAD && rsel == RSEL_AC_III && k == MASK_ZERO
        |=> acc_q == 2'(~$past(acc_q) + {1'b0, $past(carry_input_in)}))
        else $error("complement of accumulator wrong");

    AST_CLEAR_OR_SET: assert property (
        grp == GRP_DEC && rgrp != RG_I && rsel[0] && k == MASK_ZERO |=>
        acc_q == ($past(carry_input_in) ? RST_WORD : MASK_ONES))
        else $error("carry minus one not written");

    AST_ACC_KEPT: assert property (
        s_gp_reg_op(GRP_SUM_REG) |=> $stable(acc_q))
        else $error("accumulator changed by register-only add");

    // carry enable checked against the decoded code, right enable against the carry enable
    AST_CARRY_FLOATS: assert property (
        carry_output_oe_out == !(grp == GRP_SUM_BOTH && rgrp == RG_III) &&
        shift_right_out_oe_out == !carry_output_oe_out)
        else $error("carry and right output enables wrong for this code");

    AST_DEC_TO_REG: assert property (
        s_gp_reg_op(GRP_DEC) |=>
        scratch_q[$past(rsel)] == 2'(($past(acc_q) & $past(k)) - 2'h1
                                     + {1'b0, $past(carry_input_in)}))
        else $error("masked accumulator minus one not stored");

    AST_IO_SUM: assert property (
        grp == GRP_SUM_REG && rsel == RSEL_AC_III |=>
        acc_q == 2'($past(acc_q) + ($past(io_data_in) & $past(k))
                    + {1'b0, $past(carry_input_in)}))
        else $error("input bus sum into accumulator wrong");

    AST_TEST_NO_WRITE: assert property (
        grp[2] |=> $stable(acc_q) && $stable(addr_hold_q))
        else $error("test group changed accumulator or address");
endmodule
`default_nettype wire

//--- tb/bsalu_mem_model.sv
// memory partner model answering on the memory data bus
`timescale 1ns/1ps
`default_nettype none
module bsalu_mem_model
    import bsalu_pkg::*;
(
    input wire logic clk_in,
    input wire logic [SLICE_W-1:0] addr_in,
    input wire logic addr_oe_in,
    output logic [SLICE_W-1:0] mem_data_out
);
    localparam logic [1:0] CONTENT [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic [SLICE_W-1:0] last_q = 2'h0;

    // remember the last answer while the address bus is driven
    always @(posedge clk_in) begin
        if (addr_oe_in) begin
            last_q <= CONTENT[addr_in];
        end
    end

    // released address: show the inverse, never a stale copy
    always_comb begin
        mem_data_out = addr_oe_in ? CONTENT[addr_in] : ~last_q;
    end
endmodule
`default_nettype wire

//--- tb/bsalu_slice_tb_top.sv
// self-checking bench for the two-bit alu slice
`timescale 1ns/1ps
`default_nettype none
module bsalu_slice_tb_top
    import bsalu_pkg::*;
;
    typedef struct {
        logic [1:0] data;
        logic [1:0] addr;
        logic sh;
        logic sro;
        logic aoe;
        logic doe;
        logic cok;
        logic co;
        logic gpk;
        logic g;
        logic p;
    } bsalu_note_s;

    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [6:0] func = 7'h40;
    logic [1:0] mask = 2'h0;
    logic [1:0] io = 2'h0;
    logic ci = 1'b0;
    logic li = 1'b0;
    logic aen = 1'b0;
    logic den = 1'b0;
    logic [1:0] mem;
    logic gen, prop, co, co_oe, sro, sro_oe, aoe, doe;
    logic [1:0] addr_out, data_out;
    logic [1:0] regs [NUM_SCRATCH];
    logic [1:0] acc = 2'h0;
    logic [1:0] address_hold_register = 2'h0;
    bsalu_note_s note_q [$];
    int seed = 30296;
    int bad_count = 0;
    int check_count = 0;

    always #2 ref_clk_in = ~ref_clk_in;

    bsalu_slice bsalu_slice_inst (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .func_in(func), .mask_in(mask),
        .mem_data_in(mem), .io_data_in(io), .carry_input_in(ci),
        .left_fill_input_in(li), .addr_enable_in(aen),
        .data_enable_in(den), .cla_gen_out(gen), .cla_prop_out(prop),
        .carry_output_out(co), .carry_output_oe_out(co_oe),
        .shift_right_out_out(sro), .shift_right_out_oe_out(sro_oe),
        .addr_out(addr_out), .addr_oe_out(aoe), .data_out(data_out),
        .data_oe_out(doe));

    bsalu_mem_model bsalu_mem_model_inst (.clk_in(ref_clk_in),
        .addr_in(addr_out), .addr_oe_in(aoe), .mem_data_out(mem));

    task automatic check(input string what, input logic [1:0] exp,
                         input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // write a register-select target: Rn, T or the accumulator
    task automatic put(input logic [3:0] c, input logic [1:0] v);
        if (c <= RSEL_LAST_GP) begin
            regs[c] = v;
        end else if (c[0]) begin
            acc = v;
        end else begin
            regs[TEMP_IDX] = v;
        end
    endtask

    // drive one microfunction and note what the next edge must show
    task automatic do_op(input logic [6:0] f, input logic [1:0] k);
        logic [1:0] m, rv, at, res, gg, pp;
        logic [2:0] s3;
        logic [3:0] c;
        logic rg2, rg3;
        logic [31:0] r;
        bsalu_note_s n;
        @(negedge ref_clk_in);
        r = $random(seed);
        func = f;
        mask = k;
        io = r[1:0];
        ci = r[2];
        li = r[3];
        aen = r[4];
        den = r[5];
        #1;
        m = mem;
        c = f[3:0];
        rg2 = (c == 4'ha || c == 4'hb);
        rg3 = (c == 4'he || c == 4'hf);
        at = c[0] ? acc : regs[TEMP_IDX];
        rv = (c <= RSEL_LAST_GP) ? regs[c] : at;
        n.sh = 1'b0;
        n.sro = 1'b0;
        n.cok = 1'b0;
        n.gpk = 1'b0;
        n.g = 1'b0;
        n.p = 1'b0;
        s3 = {1'b0, rv} + {1'b0, acc & k} + {2'h0, ci};
        n.co = s3[2];
        case (f[6:4])
            3'h0: begin
                if (rg3) begin
                    n.sh = 1'b1;
                    n.sro = at[0];
                    put(c, {li, at[1]});
                end else if (rg2) begin
                    put(c, m + (acc & k) + ci);
                end else begin
                    res = rv + (acc & k) + ci;
                    gg = rv & (acc & k);
                    pp = rv | (acc & k);
                    n.g = gg[1] | (pp[1] & gg[0]);
                    n.p = pp[1] & pp[0];
                    n.gpk = 1'b1;
                    put(c, res);
                    acc = res;
                    n.cok = 1'b1;
                end
            end
            3'h1: begin
                if (rg3) begin
                    put(c, (~at | k) + (at & k) + ci);
                end else if (rg2) begin
                    address_hold_register = k | m;
                    put(c, m + k + ci);
                end else begin
                    address_hold_register = k | rv;
                    put(c, rv + k + ci);
                end
            end
            3'h2: put(c, ((rg3 ? io : acc) & k) - 2'h1 + ci);
            3'h3: begin
                if (rg3) begin
                    put(c, at + (io & k) + ci);
                end else if (rg2) begin
                    put(c, m + (acc & k) + ci);
                end else begin
                    put(c, rv + (acc & k) + ci);
                end
            end
            default: begin
                // test groups: carry pin is the word-wide or
                res = rg3 ? at : (rg2 ? m : rv);
                n.co = ci | (|(res & k));
                n.cok = 1'b1;
            end
        endcase
        n.data = acc;
        n.addr = address_hold_register;
        n.aoe = aen;
        n.doe = den;
        note_q.push_back(n);
    endtask

    // combinational pins taken before the edge lands, buses after
    initial begin : monitor
        bsalu_note_s n;
        logic s_sh, s_co_oe, s_sro, s_aoe, s_doe, s_co, s_gen, s_prop;
        forever begin
            @(negedge ref_clk_in);
            #1.5;
            s_sh = sro_oe;
            s_co_oe = co_oe;
            s_sro = sro;
            s_aoe = aoe;
            s_doe = doe;
            s_co = co;
            s_gen = gen;
            s_prop = prop;
            @(posedge ref_clk_in);
            #1;
            if (note_q.size() > 0) begin
                n = note_q.pop_front();
                check("shift_oe", {1'b0, n.sh}, {1'b0, s_sh});
                check("carry_oe", {1'b0, !n.sh}, {1'b0, s_co_oe});
                if (n.sh) check("shift_out", {1'b0, n.sro}, {1'b0, s_sro});
                if (n.cok) check("carry_out", {1'b0, n.co}, {1'b0, s_co});
                if (n.gpk) begin
                    check("cla_g", {1'b0, n.g}, {1'b0, s_gen});
                    check("cla_p", {1'b0, n.p}, {1'b0, s_prop});
                end
                check("addr_oe", {1'b0, n.aoe}, {1'b0, s_aoe});
                check("data_oe", {1'b0, n.doe}, {1'b0, s_doe});
                check("data_out", n.data, data_out);
                check("addr_out", n.addr, addr_out);
            end
        end
    end

    // reset, full code sweep, then random traffic
    initial begin
        logic [31:0] r;
        int i;
        for (i = 0; i < NUM_SCRATCH; i++) begin
            regs[i] = 2'h0;
        end
        repeat (6) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        check("reset_data", 2'h0, data_out);
        check("reset_addr", 2'h0, addr_out);
        repeat (2) @(posedge ref_clk_in);
        // every group, register code and mask pattern once
        for (i = 0; i < 512; i++) begin
            do_op(i[8:2], i[1:0]);
        end
        for (i = 0; i < 600; i++) begin
            r = $random(seed);
            do_op(r[6:0], r[8:7]);
        end
        for (i = 0; i < 10 && note_q.size() > 0; i++) begin
            @(posedge ref_clk_in);
        end
        #2;
        if (note_q.size() > 0) begin
            bad_count++;
            $display("[FAIL] note_queue expected 0 seen %0d", note_q.size());
        end
        final_report();
    end
endmodule
`default_nettype wire
